/* inc/radio_cmd_pkg.sv */
// constants, states and carrier types for the radio setting command block
package radio_cmd_pkg;
  // command bytes and prompt
  localparam logic [7:0] CMD_CHANNEL = 8'h43;
  localparam logic [7:0] CMD_POWER = 8'h50;
  localparam logic [7:0] CMD_STRENGTH = 8'h53;
  localparam logic [7:0] CMD_TEMP = 8'h55;
  localparam logic [7:0] CMD_SUPPLY = 8'h56;
  localparam logic [7:0] CMD_EXIT = 8'h58;
  localparam logic [7:0] PROMPT_BYTE = 8'h3E;
  // register byte offsets
  localparam logic [7:0] OFS_NV_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // nv config and status field positions
  localparam int CHAN_POS = 0;
  localparam int POWER_POS = 8;
  localparam int RATE_POS = 12;
  localparam int APPEND_POS = 16;
  localparam int VARIANT_POS = 20;
  localparam int CMDMODE_POS = 16;
  // factory defaults
  localparam logic [5:0] CHAN_RESET = 6'h01;
  localparam logic [2:0] POWER_RESET = 3'h5;
  localparam logic [2:0] RATE_RESET = 3'h3;
  localparam logic APPEND_RESET = 1'b0;
  localparam logic [1:0] VARIANT_RESET = 2'h0;
  // variants: 0 17 ch, 1 15 ch, 2 16 ch (9 dBm top), 3 50 ch
  localparam logic [1:0] VAR_868 = 2'h2;
  localparam logic [5:0] MAXCH_V0 = 6'd17;
  localparam logic [5:0] MAXCH_V1 = 6'd15;
  localparam logic [5:0] MAXCH_V2 = 6'd16;
  localparam logic [5:0] MAXCH_V3 = 6'd50;
  localparam logic [2:0] POWER_MAX = 3'h5;
  localparam logic [2:0] RATE_MAX = 3'h6;
  // 902 MHz base in half-MHz units, channel n adds n half-MHz steps
  localparam logic [11:0] BASE_HALF_MHZ = 12'h0_70C;
  // strength saturation at -30 dBm, counts of 0.5 dB
  localparam logic [7:0] STRENGTH_SAT = 8'h3C;
  localparam logic [7:0] TEMP_OFFSET = 8'h80;
  localparam logic [15:0] SUPPLY_STEP_MV = 16'h001E;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_PROMPT = 7'b000_0010,
    ST_CMD = 7'b000_0100,
    ST_ARG_CHAN = 7'b000_1000,
    ST_ARG_POWER = 7'b001_0000,
    ST_SEND_VAL = 7'b010_0000,
    ST_APPEND = 7'b100_0000
  } cmd_state_e;

  typedef struct packed {
    logic [5:0] chan;
    logic [2:0] power;
    logic [2:0] rate;
  } radio_setting_s;

  typedef struct packed {
    logic signed [7:0] power_dbm;
    logic [16:0] rate_bps;
    logic [11:0] freq_half_mhz;
  } radio_decode_s;
endpackage

/* verif/host_model.sv */
// host controller model on the command byte link
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic hclk,
  output logic config_n,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got_q[$];
  logic slow;
  initial begin
    config_n = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
  end
  // collect device bytes, stall every other cycle when slow
  always @(posedge hclk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_data);
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
  // config pin level driven by the host
  task set_cfg(input logic v);
    @(posedge hclk);
    config_n <= v;
  endtask
  // one raw byte, released line shows the inverse
  task send(input logic [7:0] b);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  // next byte from the device, host waits up to 300 cycles for it before going on
  task pop(output logic [7:0] b, output logic ok);
    int k;
    k = 0;
    while (got_q.size() == 0 && k < 300) begin
      @(posedge hclk);
      k++;
    end
    ok = got_q.size() != 0;
    b = ok ? got_q.pop_front() : 8'h00;
  endtask
endmodule
`default_nettype wire

/* verif/radio_cmd_assertions.sv */
// port-level assertions for the radio setting command block
`timescale 1ns/1ns
`default_nettype none
module radio_cmd_checker
  import radio_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic config_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic signed [7:0] temp_c,
  input wire radio_cmd_pkg::radio_setting_s radio_setting,
  input wire radio_cmd_pkg::radio_decode_s radio_decode,
  input wire logic cmd_mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // status read taken, config pin falling on an idle link
  sequence status_rd;
    hsel && htrans[1] && hready && !hwrite && haddr == 32'h0000_0004;
  endsequence
  sequence cfg_fall;
    $fell(config_n) && !cmd_mode && !tx_valid;
  endsequence
  sequence temp_req;
    rx_valid && rx_data == CMD_TEMP && cmd_mode && !tx_valid;
  endsequence
  // link, mode and readout timing
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped before accept");
  entry_prompt_a: assert property (cfg_fall |-> ##[1:4] tx_valid && tx_data == PROMPT_BYTE)
    else $error("no prompt after config pin fall");
  mode_enter_a: assert property ($fell(config_n) |-> ##[1:3] cmd_mode)
    else $error("command mode not entered");
  temp_value_a: assert property (temp_req |-> ##[1:4] tx_valid && tx_data == (temp_c ^ 8'h80))
    else $error("temperature byte wrong");
  // working setting and its decode
  setting_hold_a: assert property (cmd_mode ##1 cmd_mode |-> $stable(radio_setting))
    else $error("setting changed inside command mode");
  rate_decode_a: assert property (radio_setting.rate == 3'h3 ##1 $stable(radio_setting)
    |-> radio_decode.rate_bps == 17'h0_4A38) else $error("rate code 3 decode wrong");
  power_decode_a: assert property (radio_setting.power == 3'h1 ##1 $stable(radio_setting)
    |-> radio_decode.power_dbm == -8'sd20) else $error("power code 1 decode wrong");
  status_read_a: assert property (status_rd |=> hrdata[16:0] == {$past(cmd_mode), 1'b0,
    $past(radio_setting.rate), 1'b0, $past(radio_setting.power), 2'b00,
    $past(radio_setting.chan)}) else $error("status read mismatch");
endmodule
bind radio_setting_monitor_cmds radio_cmd_checker chk (.*);
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the radio setting command block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import radio_cmd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, config_n, rx_valid, tx_valid, tx_ready, cmd_mode;
  logic [7:0] rx_data, tx_data;
  logic [7:0] strength_att = 8'h50;
  logic pkt_done = 1'b0;
  logic [7:0] pkt_strength_att = 8'h64;
  logic signed [7:0] temp_c = 8'sh18;
  logic [11:0] supply_mv = 12'hC30;
  radio_setting_s radio_setting;
  radio_decode_s radio_decode;
  logic [16:0] rate_tab [6] = '{17'h0_04B0, 17'h0_12C0, 17'h0_4A38, 17'h0_8000, 17'h1_2C00,
    17'h1_86A0};
  logic [7:0] dbm_tab [6] = '{8'hEC, 8'hF6, 8'h00, 8'h05, 8'h0A, 8'h0A};
  int n_mismatch = 0;
  int checked = 0;
  always #4 hclk = ~hclk;
  radio_setting_monitor_cmds dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .config_n(config_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .strength_att(strength_att), .pkt_done(pkt_done),
    .pkt_strength_att(pkt_strength_att), .temp_c(temp_c), .supply_mv(supply_mv),
    .radio_setting(radio_setting), .radio_decode(radio_decode), .cmd_mode(cmd_mode));
  host_model host (.hclk(hclk), .config_n(config_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // compare, verdict and hang exit
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task bail;
    n_mismatch++;
    final_report;
  endtask
  // bus transfer: address phase, then data phase, both until hready
  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) bail;
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // command link helpers
  task expect_byte(input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    host.pop(b, ok);
    if (!ok) bail;
    check({24'h0, b}, {24'h0, exp});
  endtask
  task arg_cmd(input logic [7:0] c, input logic [7:0] a);
    host.send(c);
    expect_byte(PROMPT_BYTE);
    host.send(a);
    expect_byte(PROMPT_BYTE);
  endtask
  task read_cmd(input logic [7:0] c, input logic [7:0] v);
    host.send(c);
    expect_byte(v);
    expect_byte(PROMPT_BYTE);
  endtask
  task enter;
    host.set_cfg(1'b0);
    expect_byte(PROMPT_BYTE);
    host.set_cfg(1'b1);
  endtask
  task leave;
    int k;
    host.send(CMD_EXIT);
    k = 0;
    while (cmd_mode !== 1'b0 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    if (cmd_mode !== 1'b0) bail;
    repeat (2) @(posedge hclk);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check(32'(radio_setting), 32'h0000_006B);
    ahb(1'b0, 32'(OFS_NV_CONFIG), 32'h0000_0000);
    check(rd, 32'h0000_3501);
    ahb(1'b1, 32'h0000_0008, 32'h0000_6000);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    check(32'(radio_decode.rate_bps), 32'h0000_4A38);
    check({24'h0, radio_decode.power_dbm}, 32'h0000_000A);
    enter;
    host.slow <= 1'b1;
    read_cmd(CMD_STRENGTH, 8'h50);
    strength_att <= 8'h10;
    read_cmd(CMD_STRENGTH, STRENGTH_SAT);
    read_cmd(CMD_TEMP, 8'h98);
    read_cmd(CMD_SUPPLY, 8'h68);
    host.slow <= 1'b0;
    arg_cmd(CMD_CHANNEL, 8'h00);
    arg_cmd(CMD_CHANNEL, 8'h12);
    arg_cmd(CMD_CHANNEL, 8'h11);
    arg_cmd(CMD_POWER, 8'h06);
    arg_cmd(CMD_POWER, 8'h02);
    host.send(8'h41);
    expect_byte(PROMPT_BYTE);
    ahb(1'b0, 32'(OFS_STATUS), 32'h0000_0000);
    check(rd, 32'h0001_3501);
    leave;
    check(32'(radio_setting), 32'h0000_0453);
    for (int i = 1; i <= 6; i++) begin
      ahb(1'b1, 32'(OFS_NV_CONFIG), 32'h0000_0511 | (i << 12));
      check(32'(radio_setting.rate), (i == 1) ? 32'h0000_0003 : 32'(i - 1));
      enter;
      arg_cmd(CMD_POWER, (i > 5) ? 8'h05 : 8'(i));
      leave;
      check(32'(radio_decode.rate_bps), 32'(rate_tab[i - 1]));
      check({24'h0, radio_decode.power_dbm}, {24'h0, dbm_tab[i - 1]});
    end
    ahb(1'b1, 32'(OFS_NV_CONFIG), 32'h0000_7511);
    ahb(1'b0, 32'(OFS_NV_CONFIG), 32'h0000_0000);
    check(rd, 32'h0000_6511);
    ahb(1'b1, 32'(OFS_NV_CONFIG), 32'h0031_3501);
    enter;
    arg_cmd(CMD_POWER, 8'h03);
    arg_cmd(CMD_CHANNEL, 8'h32);
    leave;
    check(32'(radio_decode.freq_half_mhz), 32'h0000_073E);
    // 16-channel variant: channel 17 refused, top power level is 9 dBm
    ahb(1'b1, 32'(OFS_NV_CONFIG), 32'h0021_3501);
    enter;
    arg_cmd(CMD_CHANNEL, 8'h11);
    arg_cmd(CMD_POWER, 8'h05);
    leave;
    check(32'(radio_setting.chan), 32'h0000_0032);
    check({24'h0, radio_decode.power_dbm}, 32'h0000_0009);
    pkt_done <= 1'b1;
    @(posedge hclk);
    pkt_done <= 1'b0;
    expect_byte(8'h64);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check(32'(radio_setting), 32'h0000_006B);
    final_report;
  end
endmodule
`default_nettype wire

/* verilog/radio_setting_monitor_cmds.sv */
// command interpreter for radio settings and monitor readouts, AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - channel and power commands set radio indices
// - air rate changes only via nv field
// - reset loads working settings from nv defaults
// - rate codes 1-6 decoded, 7 reserved, default 3
// - power codes 1-5 decoded to dBm per variant
// - channel range per variant, 50ch frequency formula
// - strength command returns byte then prompt
// - append packet strength byte when enabled
// - strength byte is half-dB counts, P=-byte/2
// - strength saturates near -30 dBm
// - temperature command returns byte then prompt
// - temperature byte is celsius plus 128
// - supply command returns byte then prompt
// - supply byte counts 30 mV steps
// - config pin falling edge enters mode, prompt after commands
// - command codes as bytes, raw binary arguments
// - commanded values apply on idle, volatile
module radio_setting_monitor_cmds (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic config_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] strength_att,
  input wire logic pkt_done,
  input wire logic [7:0] pkt_strength_att,
  input wire logic signed [7:0] temp_c,
  input wire logic [11:0] supply_mv,
  output radio_cmd_pkg::radio_setting_s radio_setting,
  output radio_cmd_pkg::radio_decode_s radio_decode,
  output logic cmd_mode
);
  import radio_cmd_pkg::*;

  // highest valid channel for a variant
  function automatic logic [5:0] max_chan(input logic [1:0] v);
    case (v)
      2'h0: max_chan = MAXCH_V0;
      2'h1: max_chan = MAXCH_V1;
      2'h2: max_chan = MAXCH_V2;
      default: max_chan = MAXCH_V3;
    endcase
  endfunction

  // half-dB attenuation to strength byte, clamped at saturation
  function automatic logic [7:0] strength_byte(input logic [7:0] att);
    strength_byte = (att < STRENGTH_SAT) ? STRENGTH_SAT : att;
  endfunction

  // non-volatile configuration fields
  logic [5:0] channel_default_index_r;
  logic [2:0] power_default_level_r;
  logic [2:0] air_rate_default_code_r;
  logic strength_append_enable_r;
  logic [1:0] variant_r;
  // working and pending settings
  radio_setting_s work_r;
  logic [5:0] pend_chan_r;
  logic [2:0] pend_power_r;
  logic load_r;
  cmd_state_e state_r;
  logic [7:0] val_r;
  logic val_prompt_r;
  logic config_n_d_r;
  logic [7:0] pkt_byte_r;
  logic pkt_pend_r;
  // bus address phase capture
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] nv_word;
  logic [31:0] status_word;
  logic [15:0] supply_steps;
  logic [7:0] supply_byte;
  logic bus_take;
  logic tx_free;

  assign bus_take = hsel && htrans[1] && hready;
  assign tx_free = !tx_valid || tx_ready;
  assign supply_steps = 16'(supply_mv) / SUPPLY_STEP_MV;
  assign supply_byte = (supply_steps > 16'h00FF) ? 8'hFF : supply_steps[7:0];

  // register images
  always_comb begin
    nv_word = 32'h0000_0000;
    nv_word[CHAN_POS +: 6] = channel_default_index_r;
    nv_word[POWER_POS +: 3] = power_default_level_r;
    nv_word[RATE_POS +: 3] = air_rate_default_code_r;
    nv_word[APPEND_POS] = strength_append_enable_r;
    nv_word[VARIANT_POS +: 2] = variant_r;
    status_word = 32'h0000_0000;
    // image of the setting applied to the radio, so it agrees with the radio port
    status_word[CHAN_POS +: 6] = radio_setting.chan;
    status_word[POWER_POS +: 3] = radio_setting.power;
    status_word[RATE_POS +: 3] = radio_setting.rate;
    status_word[CMDMODE_POS] = cmd_mode;
  end

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      wr_pend_r <= bus_take && hwrite;
      if (bus_take) begin
        wr_addr_r <= haddr[7:0];
      end
      if (bus_take && !hwrite) begin
        case (haddr[7:0])
          OFS_NV_CONFIG: hrdata <= nv_word;
          OFS_STATUS: hrdata <= status_word;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // nv configuration writes; reserved rate codes 0 and 7 keep the old value, other fields stored as written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_default_index_r <= CHAN_RESET;
      power_default_level_r <= POWER_RESET;
      air_rate_default_code_r <= RATE_RESET;
      strength_append_enable_r <= APPEND_RESET;
      variant_r <= VARIANT_RESET;
    end else if (wr_pend_r && wr_addr_r == OFS_NV_CONFIG) begin
      channel_default_index_r <= hwdata[CHAN_POS +: 6];
      power_default_level_r <= hwdata[POWER_POS +: 3];
      if (hwdata[RATE_POS +: 3] != 3'h0 && hwdata[RATE_POS +: 3] <= RATE_MAX) begin
        air_rate_default_code_r <= hwdata[RATE_POS +: 3];
      end
      strength_append_enable_r <= hwdata[APPEND_POS];
      variant_r <= hwdata[VARIANT_POS +: 2];
    end
  end

  // working settings: loaded from nv after reset, commands applied on idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_r <= 1'b1;
      work_r <= '{chan: CHAN_RESET, power: POWER_RESET, rate: RATE_RESET};
    end else begin
      load_r <= 1'b0;
      if (load_r) begin
        work_r.chan <= channel_default_index_r;
        work_r.power <= power_default_level_r;
        work_r.rate <= air_rate_default_code_r;
      end else if (state_r == ST_CMD && rx_valid && rx_data == CMD_EXIT) begin
        work_r.chan <= pend_chan_r;
        work_r.power <= pend_power_r;
        work_r.rate <= air_rate_default_code_r;
      end
    end
  end

  // pending command values, volatile only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_chan_r <= CHAN_RESET;
      pend_power_r <= POWER_RESET;
    end else if (load_r) begin
      pend_chan_r <= channel_default_index_r;
      pend_power_r <= power_default_level_r;
    end else if (rx_valid) begin
      if (state_r == ST_ARG_CHAN && rx_data != 8'h00
          && rx_data <= {2'b00, max_chan(variant_r)}) begin
        pend_chan_r <= rx_data[5:0];
      end
      if (state_r == ST_ARG_POWER && rx_data != 8'h00 && rx_data <= {5'h00, POWER_MAX}) begin
        pend_power_r <= rx_data[2:0];
      end
    end
  end

  // packet strength capture for appending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_pend_r <= 1'b0;
      pkt_byte_r <= 8'h00;
    end else if (pkt_done && strength_append_enable_r) begin
      pkt_pend_r <= 1'b1;
      pkt_byte_r <= strength_byte(pkt_strength_att);
    end else if (state_r == ST_APPEND) begin
      pkt_pend_r <= 1'b0;
    end
  end

  // command sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      val_r <= 8'h00;
      val_prompt_r <= 1'b0;
      config_n_d_r <= 1'b1;
    end else begin
      config_n_d_r <= config_n;
      case (state_r)
        ST_IDLE: begin
          if (config_n_d_r && !config_n) begin
            state_r <= ST_PROMPT;
          end else if (pkt_pend_r) begin
            state_r <= ST_APPEND;
          end
        end
        ST_PROMPT: begin
          if (tx_free) begin
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (rx_valid) begin
            case (rx_data)
              CMD_CHANNEL: state_r <= ST_PROMPT;
              CMD_POWER: state_r <= ST_PROMPT;
              CMD_EXIT: state_r <= ST_IDLE;
              CMD_STRENGTH: begin
                val_r <= strength_byte(strength_att);
                state_r <= ST_SEND_VAL;
              end
              CMD_TEMP: begin
                val_r <= 8'(temp_c) + TEMP_OFFSET;
                state_r <= ST_SEND_VAL;
              end
              CMD_SUPPLY: begin
                val_r <= supply_byte;
                state_r <= ST_SEND_VAL;
              end
              default: state_r <= ST_PROMPT;
            endcase
          end
        end
        ST_ARG_CHAN, ST_ARG_POWER: begin
          if (rx_valid) begin
            state_r <= ST_PROMPT;
          end
        end
        ST_SEND_VAL: begin
          if (tx_free) begin
            state_r <= ST_PROMPT;
          end
        end
        ST_APPEND: begin
          if (tx_free) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // argument byte follows its command prompt
      if (state_r == ST_CMD && rx_valid && rx_data == CMD_CHANNEL) begin
        val_prompt_r <= 1'b1;
        val_r <= 8'h01;
      end else if (state_r == ST_CMD && rx_valid && rx_data == CMD_POWER) begin
        val_prompt_r <= 1'b1;
        val_r <= 8'h02;
      end else if (state_r == ST_PROMPT && tx_free) begin
        val_prompt_r <= 1'b0;
        if (val_prompt_r && val_r == 8'h01) begin
          state_r <= ST_ARG_CHAN;
        end else if (val_prompt_r && val_r == 8'h02) begin
          state_r <= ST_ARG_POWER;
        end
      end
    end
  end

  // serial byte output, held until taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (tx_free) begin
      tx_valid <= 1'b0;
      case (state_r)
        ST_PROMPT: begin
          tx_valid <= 1'b1;
          tx_data <= PROMPT_BYTE;
        end
        ST_SEND_VAL: begin
          tx_valid <= 1'b1;
          tx_data <= val_r;
        end
        ST_APPEND: begin
          tx_valid <= 1'b1;
          tx_data <= pkt_byte_r;
        end
        default: tx_valid <= 1'b0;
      endcase
    end
  end

  // radio outputs and decoded values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_setting <= '{chan: CHAN_RESET, power: POWER_RESET, rate: RATE_RESET};
      radio_decode <= '0;
      cmd_mode <= 1'b0;
    end else begin
      radio_setting <= work_r;
      cmd_mode <= (state_r != ST_IDLE) && (state_r != ST_APPEND);
      case (work_r.power)
        3'h1: radio_decode.power_dbm <= -8'sd20;
        3'h2: radio_decode.power_dbm <= -8'sd10;
        3'h3: radio_decode.power_dbm <= 8'sd0;
        3'h4: radio_decode.power_dbm <= 8'sd5;
        default: radio_decode.power_dbm <= (variant_r == VAR_868) ? 8'sd9 : 8'sd10;
      endcase
      case (work_r.rate)
        3'h1: radio_decode.rate_bps <= 17'd1200;
        3'h2: radio_decode.rate_bps <= 17'd4800;
        3'h3: radio_decode.rate_bps <= 17'd19000;
        3'h4: radio_decode.rate_bps <= 17'd32768;
        3'h5: radio_decode.rate_bps <= 17'd76800;
        3'h6: radio_decode.rate_bps <= 17'd100000;
        default: radio_decode.rate_bps <= 17'd0;
      endcase
      radio_decode.freq_half_mhz <= BASE_HALF_MHZ + {6'h00, work_r.chan};
    end
  end
endmodule

`default_nettype wire
